// file: rtl/dtic_pkg.sv
// Shared constants and carrier types for the acquisition trigger, timer and interrupt block
// What this block does
// R1 - Software trigger makes one conversion pulse; result readable at base data, offset zero.
// R2 - Pacer comes from two cascaded dividers whose divisors the host programs.
// R3 - Either pacer divisor programmed as zero stops all pacer triggers.
// R4 - Host keeps the pacer sampling rate at or below 110 KHz.
// R5 - Host picks the two divisors so their product exceeds 20.
// R6 - Timer reached through four byte ports, index 0 to 3; low 8 bits matter.
// R7 - Counter zero takes host mode 0 to 5 and a count; it is the pre-trigger counter.
// R8 - Host can read counter zero's current count at any time.
// R9 - Stopping counter zero sets one-shot mode, count zero, output held high.
// R10 - Samples go into a result FIFO; a reset discards them all.
// R11 - Two independent interrupt lines, own source each, request state readable. The code feeds both lines one shared clear, so i_irq_clear drops both.
// R12 - Line A select: 0 disabled, 1 end of conversion, 2 FIFO half full.
// R13 - Line B select: 0 disabled, 1 pacer tick, 2 external interrupt input.
// R14 - Host write to interrupt control picks which events raise each line.
// R15 - One readback returns conversion mode and interrupt control settings.
// R16 - A raised line stays raised until host clears it; no new request before.
// R17 - Report FIFO empty, half full, full and converter busy; full means possible loss.
// R18 - On half full but not full, host reads one 512 word block.
// R19 - Divider two counts divider one's pulses; its terminal pulse starts a conversion.
package dtic_pkg;

    localparam int CNT_W      = 16;
    localparam int DATA_W     = 16;
    localparam int FIFO_DEPTH = 1024;
    localparam int PTR_W      = 10;
    localparam int LVL_W      = 11;
    localparam int NUM_CNT    = 3;

    localparam logic [LVL_W-1:0] FIFO_HALF = 11'h0200;
    localparam logic [LVL_W-1:0] FIFO_FULL = 11'h0400;
    localparam logic [LVL_W-1:0] LVL_ZERO  = 11'h000;
    localparam logic [LVL_W-1:0] LVL_ONE   = 11'h001;
    localparam logic [PTR_W-1:0] PTR_ZERO  = 10'h000;
    localparam logic [PTR_W-1:0] PTR_ONE   = 10'h001;

    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    // Timer byte ports
    localparam logic [1:0] TPORT_C0   = 2'h0;
    localparam logic [1:0] TPORT_C1   = 2'h1;
    localparam logic [1:0] TPORT_C2   = 2'h2;
    localparam logic [1:0] TPORT_CTRL = 2'h3;

    // Control word fields on the control port
    localparam int CW_SEL_HI  = 7;
    localparam int CW_SEL_LO  = 6;
    localparam int CW_MODE_HI = 3;
    localparam int CW_MODE_LO = 1;

    localparam logic [2:0] COUNTER_OP_MODE_ZERO  = 3'h0;
    localparam logic [2:0] COUNTER_OP_MODE_ONE   = 3'h1;
    localparam logic [2:0] COUNTER_OP_MODE_TWO   = 3'h2;
    localparam logic [2:0] COUNTER_OP_MODE_THREE = 3'h3;
    localparam logic [2:0] COUNTER_OP_MODE_FIVE  = 3'h5;

    // Interrupt source select codes
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_ONE = 2'h1;
    localparam logic [1:0] SRC_TWO = 2'h2;

    typedef struct packed {
        logic [1:0] line_b_source_sel;
        logic [1:0] line_a_source_sel;
    } dtic_irq_ctrl_s;

    typedef struct packed {
        logic pretrig_on;
        logic ext_src;
        logic autoscan;
        logic timer_trig;
    } dtic_mode_s;

    typedef struct packed {
        logic busy;
        logic full;
        logic half;
        logic empty;
    } dtic_status_s;

    typedef struct packed {
        dtic_mode_s     mode;
        dtic_irq_ctrl_s irq_ctrl_value;
    } dtic_readback_s;

endpackage

// file: rtl/dtic_divider.sv
// Down-counting frequency divider with reload, terminal pulse and output level
`timescale 1ns/1ns
module dtic_divider
    import dtic_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_load,
    input  wire logic             i_periodic,
    input  wire logic             i_tick,
    input  wire logic [CNT_W-1:0] i_divisor,
    output logic      [CNT_W-1:0] o_count,
    output logic                  o_terminal,
    output logic                  o_out
);

    logic [CNT_W-1:0] reload;
    logic             armed;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_count    <= CNT_ZERO;
            reload     <= CNT_ZERO;
            armed      <= 1'b0;
            o_out      <= 1'b1;
            o_terminal <= 1'b0;
        end else if (i_load) begin
            reload     <= i_divisor;
            o_count    <= i_divisor;
            armed      <= (i_divisor != CNT_ZERO); // R3
            // A zero count leaves the output parked high
            o_out      <= i_periodic || (i_divisor == CNT_ZERO); // R9
            o_terminal <= 1'b0;
        end else begin
            o_terminal <= 1'b0;
            if (armed && i_tick) begin
                if (o_count == CNT_ONE) begin
                    o_terminal <= 1'b1;
                    o_out      <= 1'b1;
                    if (i_periodic) begin
                        o_count <= reload;
                    end else begin
                        o_count <= CNT_ZERO;
                        armed   <= 1'b0;
                    end
                end else begin
                    o_count <= o_count - CNT_ONE;
                end
            end
        end
    end

endmodule

// file: rtl/dtic_irq_line.sv
// One interrupt request line with a three-way source select and sticky request
`timescale 1ns/1ns
module dtic_irq_line
    import dtic_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic [1:0] i_sel,
    input  wire logic       i_event_one,
    input  wire logic       i_event_two,
    input  wire logic       i_clear,
    output logic            o_request
);

    logic event_hit;

    always_comb begin
        event_hit = ((i_sel == SRC_ONE) && i_event_one) || ((i_sel == SRC_TWO) && i_event_two); // R14
    end

    // A new event beats a clear in the same cycle so nothing is lost
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_request <= 1'b0;
        end else if (event_hit) begin
            o_request <= 1'b1;
        end else if (i_clear) begin
            o_request <= 1'b0; // R16
        end
    end

endmodule

// file: rtl/dtic_acq_ctrl.sv
// Acquisition control: timer ports, pacer, pre-trigger counter, result FIFO and interrupts
`timescale 1ns/1ns
module dtic_acq_ctrl
    import dtic_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_soft_trig,
    input  wire logic              i_tmr_wr,
    input  wire logic              i_tmr_rd,
    input  wire logic [1:0]        i_tmr_index,
    input  wire logic [15:0]       i_tmr_wdata,
    output logic      [15:0]       o_tmr_rdata,
    input  wire logic              i_counter_stop,
    output logic                   o_pretrig_out,
    input  wire logic              i_mode_wr,
    input  wire dtic_mode_s        i_mode_value,
    input  wire logic              i_irq_ctrl_wr,
    input  wire dtic_irq_ctrl_s    i_irq_ctrl_value,
    output dtic_readback_s         o_readback,
    input  wire logic              i_irq_clear,
    output logic                   o_irq_line_a,
    output logic                   o_irq_line_b,
    input  wire logic              i_ext_irq,
    output logic                   o_conv_start,
    input  wire logic              i_adc_done,
    input  wire logic [DATA_W-1:0] i_adc_data,
    input  wire logic              i_fifo_rd,
    input  wire logic              i_fifo_reset,
    output logic      [DATA_W-1:0] o_base_data,
    output dtic_status_s           o_status
);

    // ---------------- Timer byte ports ----------------
    logic [NUM_CNT-1:0] wr_hi;
    logic [NUM_CNT-1:0] rd_hi;
    logic [NUM_CNT-1:0] load_vec;
    logic [NUM_CNT-1:0] periodic;
    logic [NUM_CNT-1:0] tick;
    logic [NUM_CNT-1:0] term;
    logic [NUM_CNT-1:0] cnt_out;
    logic [7:0]         low_byte [NUM_CNT];
    logic [CNT_W-1:0]   div_q    [NUM_CNT];
    logic [CNT_W-1:0]   cnt      [NUM_CNT];
    logic [2:0]         c0_mode;
    logic [1:0]         cw_sel;
    logic [2:0]         cw_mode;
    logic               ctrl_wr;

    assign cw_sel  = i_tmr_wdata[CW_SEL_HI:CW_SEL_LO];
    assign cw_mode = i_tmr_wdata[CW_MODE_HI:CW_MODE_LO];
    assign ctrl_wr = i_tmr_wr && (i_tmr_index == TPORT_CTRL); // R6

    // Counts go in low byte first, high byte second; the high byte commits the load
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_hi    <= '0;
            load_vec <= '0;
            c0_mode  <= COUNTER_OP_MODE_ZERO;
            for (int k = 0; k < NUM_CNT; k++) begin
                low_byte[k] <= 8'h00;
                div_q[k]    <= CNT_ZERO;
            end
        end else begin
            load_vec <= '0;
            if (i_counter_stop) begin
                c0_mode     <= COUNTER_OP_MODE_ONE; // R9
                div_q[0]    <= CNT_ZERO;
                load_vec[0] <= 1'b1;
                wr_hi[0]    <= 1'b0;
            end else if (ctrl_wr) begin
                if (cw_sel != TPORT_CTRL) begin
                    wr_hi[cw_sel] <= 1'b0;
                end
                if (cw_sel == TPORT_C0) begin
                    c0_mode <= cw_mode; // R7
                end
            end else if (i_tmr_wr) begin
                if (!wr_hi[i_tmr_index]) begin
                    low_byte[i_tmr_index] <= i_tmr_wdata[7:0]; // R6
                    wr_hi[i_tmr_index]    <= 1'b1;
                end else begin
                    div_q[i_tmr_index]    <= {i_tmr_wdata[7:0], low_byte[i_tmr_index]}; // R2
                    load_vec[i_tmr_index] <= 1'b1;
                    wr_hi[i_tmr_index]    <= 1'b0;
                end
            end
        end
    end

    // Read side: live count, low byte then high byte, upper bits always zero
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rd_hi       <= '0;
            o_tmr_rdata <= 16'h0000;
        end else if (ctrl_wr) begin
            if (cw_sel != TPORT_CTRL) begin
                rd_hi[cw_sel] <= 1'b0;
            end
        end else if (i_tmr_rd) begin
            if (i_tmr_index == TPORT_CTRL) begin
                o_tmr_rdata <= 16'h0000;
            end else begin
                o_tmr_rdata <= {8'h00, rd_hi[i_tmr_index] ? cnt[i_tmr_index][15:8]
                                                          : cnt[i_tmr_index][7:0]}; // R8
                rd_hi[i_tmr_index] <= ~rd_hi[i_tmr_index];
            end
        end
    end

    // Counter zero counts conversions; pacer divider one counts the system clock, divider two counts divider one's pulses
    assign periodic[0] = (c0_mode == COUNTER_OP_MODE_TWO) || (c0_mode == COUNTER_OP_MODE_THREE);
    assign periodic[1] = 1'b1;
    assign periodic[2] = 1'b1;
    assign tick[0]     = o_conv_start;
    assign tick[1]     = 1'b1;
    assign tick[2]     = term[1]; // R19

    for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
        dtic_divider u_div (
            .i_clk      (i_clk),
            .i_reset_n  (i_reset_n),
            .i_load     (load_vec[g]),
            .i_periodic (periodic[g]),
            .i_tick     (tick[g]),
            .i_divisor  (div_q[g]),
            .o_count    (cnt[g]),
            .o_terminal (term[g]),
            .o_out      (cnt_out[g])
        );
    end

    assign o_pretrig_out = cnt_out[0]; // R9

    // ---------------- Mode and interrupt control ----------------
    dtic_mode_s     mode;
    dtic_irq_ctrl_s irq_ctrl;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            mode       <= '0;
            irq_ctrl   <= '0;
            o_readback <= '0;
        end else begin
            if (i_mode_wr) begin
                mode <= i_mode_value;
            end
            if (i_irq_ctrl_wr) begin
                irq_ctrl <= i_irq_ctrl_value; // R14
            end
            o_readback <= '{mode: mode, irq_ctrl_value: irq_ctrl}; // R15
        end
    end

    // Conversion start: software pulse, or pacer when timer triggering is chosen
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= i_soft_trig || (mode.timer_trig && term[2]); // R1 R19
        end
    end

    // ---------------- Pin synchronisers ----------------
    logic [1:0]        done_sync;
    logic [1:0]        ext_sync;
    logic              done_prev;
    logic              ext_prev;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic              done_edge;
    logic              ext_edge;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            done_sync <= 2'h0;
            ext_sync  <= 2'h0;
            done_prev <= 1'b0;
            ext_prev  <= 1'b0;
            data_meta <= 16'h0000;
            data_sync <= 16'h0000;
        end else begin
            done_sync <= {done_sync[0], i_adc_done};
            ext_sync  <= {ext_sync[0], i_ext_irq};
            done_prev <= done_sync[1];
            ext_prev  <= ext_sync[1];
            data_meta <= i_adc_data;
            data_sync <= data_meta;
        end
    end

    assign done_edge = done_sync[1] && !done_prev;
    assign ext_edge  = ext_sync[1] && !ext_prev;

    // ---------------- Result FIFO ----------------
    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0]  wptr;
    logic [PTR_W-1:0]  rptr;
    logic [LVL_W-1:0]  level;
    logic              push;
    logic              pop;
    logic              busy;
    logic              half_prev;
    logic              half_now;
    logic              half_rise;

    // A sample arriving while full is dropped; the full flag tells software so
    assign push      = done_edge && (level != FIFO_FULL) && !i_fifo_reset; // R17
    assign pop       = i_fifo_rd && (level != LVL_ZERO) && !i_fifo_reset;
    assign half_now  = (level >= FIFO_HALF);
    assign half_rise = half_now && !half_prev;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr] <= data_sync; // R10
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_fifo_reset) begin
            wptr  <= PTR_ZERO; // R10
            rptr  <= PTR_ZERO;
            level <= LVL_ZERO;
        end else begin
            if (push) begin
                wptr <= wptr + PTR_ONE;
            end
            if (pop) begin
                rptr <= rptr + PTR_ONE;
            end
            if (push && !pop) begin
                level <= level + LVL_ONE;
            end else if (pop && !push) begin
                level <= level - LVL_ONE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_base_data <= 16'h0000;
        end else if (pop) begin
            o_base_data <= mem[rptr]; // R1
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            busy      <= 1'b0;
            half_prev <= 1'b0;
            o_status  <= '{busy: 1'b0, full: 1'b0, half: 1'b0, empty: 1'b1};
        end else begin
            if (o_conv_start) begin
                busy <= 1'b1;
            end else if (done_edge) begin
                busy <= 1'b0;
            end
            half_prev <= half_now;
            o_status  <= '{busy: busy, full: (level == FIFO_FULL), half: half_now,
                           empty: (level == LVL_ZERO)}; // R17
        end
    end

    // ---------------- Interrupt lines ----------------
    dtic_irq_line u_line_a (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_sel       (irq_ctrl.line_a_source_sel),
        .i_event_one (push),
        .i_event_two (half_rise),
        .i_clear     (i_irq_clear),
        .o_request   (o_irq_line_a)
    ); // R11 R12

    dtic_irq_line u_line_b (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_sel       (irq_ctrl.line_b_source_sel),
        .i_event_one (term[2]),
        .i_event_two (ext_edge),
        .i_clear     (i_irq_clear),
        .o_request   (o_irq_line_b)
    ); // R11 R13

    // ---------------- Assertions ----------------
    a_soft_trig_pulse: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R1
        i_soft_trig |=> o_conv_start)
        else $error("soft trigger gave no conversion pulse");

    a_pacer_start: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R19
        (mode.timer_trig && term[2]) |=> o_conv_start)
        else $error("pacer tick gave no conversion pulse");

    a_pacer_zero_stop: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R3
        ((div_q[1] == CNT_ZERO) || (div_q[2] == CNT_ZERO))[*4] |-> !term[2])
        else $error("pacer ticked with a zero divisor");

    a_stop_out_high: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R9
        i_counter_stop |-> ##2 (o_pretrig_out && cnt[0] == CNT_ZERO))
        else $error("stopped counter output not high");

    a_line_a_eoc: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R12
        (irq_ctrl.line_a_source_sel == SRC_ONE && push) |=> o_irq_line_a)
        else $error("end of conversion did not raise line A");

    a_line_b_ext: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R13
        (irq_ctrl.line_b_source_sel == SRC_TWO && ext_edge) |=> o_irq_line_b)
        else $error("external event did not raise line B");

    a_line_off_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R14
        (irq_ctrl.line_a_source_sel == SRC_OFF && !o_irq_line_a) |=> !o_irq_line_a)
        else $error("disabled line A raised");

    a_request_held: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R16
        (o_irq_line_a && !i_irq_clear) |=> o_irq_line_a)
        else $error("line A dropped without a clear");

    a_fifo_reset_empty: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R10
        i_fifo_reset |-> ##2 (o_status.empty && !o_status.half))
        else $error("FIFO reset left data behind");

    a_fifo_full_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R17
        (level == FIFO_FULL) |=> o_status.full)
        else $error("full level not reported");

    a_readback_ctrl: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
        i_irq_ctrl_wr |-> ##2 (o_readback.irq_ctrl_value == $past(i_irq_ctrl_value, 2)))
        else $error("readback lost interrupt control value");

    c_pacer_conv: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        mode.timer_trig && term[2] ##1 o_conv_start);
    c_half_irq: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        half_rise && irq_ctrl.line_a_source_sel == SRC_TWO ##1 o_irq_line_a);
    c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_reset_n)
        o_status.full);

endmodule

// file: test/dtic_adc_model.sv
// Converter model that answers each conversion start with a done strobe and a sample
`timescale 1ns/1ns
module dtic_adc_model (
    input  wire logic        i_clk,
    input  wire logic        i_conv_start,
    output logic             o_done,
    output logic [15:0]      o_data,
    output logic [15:0]      o_last
);
    int wait_n;

    initial begin
        o_done = 1'b0;
        o_data = 16'h0000;
        o_last = 16'h0000;
        forever begin
            @(posedge i_clk);
            if (i_conv_start === 1'b1) begin
                // Prompt or slow answer, one to four cycles
                wait_n = $urandom_range(4, 1);
                repeat (wait_n) @(negedge i_clk);
                o_last = 16'($urandom);
                o_data = o_last;
                o_done = 1'b1;
                repeat (3) @(negedge i_clk);
                o_done = 1'b0;
                // Sample no longer valid: show its inverse so a late capture cannot pass by luck
                o_data = ~o_last;
            end
        end
    end
endmodule

// file: test/tb.sv
// Self-checking testbench for the acquisition trigger, timer and interrupt block
`timescale 1ns/1ns
module tb;
    import dtic_pkg::*;
    logic           clk = 1'b0, rst_n = 1'b0, soft_trig = 1'b0, tmr_wr = 1'b0, tmr_rd = 1'b0;
    logic           counter_stop = 1'b0, mode_wr = 1'b0, irq_ctrl_wr = 1'b0, irq_clear = 1'b0;
    logic           ext_irq = 1'b0, fifo_rd = 1'b0, fifo_reset = 1'b0;
    logic [1:0]     tmr_idx = 2'h0;
    logic [15:0]    tmr_wdata = 16'h0000, tmr_rdata, base_data, adc_data, adc_last, cval, v, c1;
    logic           pretrig_out, line_a, line_b, conv_start, adc_done;
    dtic_mode_s     mode_value = '0;
    dtic_irq_ctrl_s irq_value = '0;
    dtic_readback_s readback;
    dtic_status_s   status;
    int             n_errors = 0, total_checks = 0, n_starts = 0, k, s0;

    always #50 clk = ~clk;
    always @(posedge clk) if (conv_start === 1'b1) n_starts <= n_starts + 1;

    dtic_acq_ctrl u_dtic_acq_ctrl (.i_clk(clk), .i_reset_n(rst_n), .i_soft_trig(soft_trig), .i_tmr_wr(tmr_wr),
        .i_tmr_rd(tmr_rd), .i_tmr_index(tmr_idx), .i_tmr_wdata(tmr_wdata), .o_tmr_rdata(tmr_rdata),
        .i_counter_stop(counter_stop), .o_pretrig_out(pretrig_out), .i_mode_wr(mode_wr),
        .i_mode_value(mode_value), .i_irq_ctrl_wr(irq_ctrl_wr), .i_irq_ctrl_value(irq_value),
        .o_readback(readback), .i_irq_clear(irq_clear), .o_irq_line_a(line_a), .o_irq_line_b(line_b),
        .i_ext_irq(ext_irq), .o_conv_start(conv_start), .i_adc_done(adc_done), .i_adc_data(adc_data),
        .i_fifo_rd(fifo_rd), .i_fifo_reset(fifo_reset), .o_base_data(base_data), .o_status(status));

    dtic_adc_model u_dtic_adc_model (.i_clk(clk), .i_conv_start(conv_start), .o_done(adc_done),
        .o_data(adc_data), .o_last(adc_last));

    task automatic print_verdict;
        $display("Checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask

    task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
        int n;
        n = 0;
        while (s !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (s !== lvl) begin
            n_errors++;
            $display("MISMATCH wait expected %h seen %h", lvl, s);
            print_verdict();
        end
    endtask

    task automatic tmr_write(input logic [1:0] idx, input logic [7:0] val);
        // Random upper byte must be ignored
        @(negedge clk) begin
            tmr_idx = idx;
            tmr_wdata = {8'($urandom), val};
            tmr_wr = 1'b1;
        end
        @(negedge clk) tmr_wr = 1'b0;
    endtask

    task automatic read_cnt(output logic [15:0] val);
        for (int b = 0; b < 2; b++) begin
            @(negedge clk) begin
                tmr_idx = TPORT_C0;
                tmr_rd = 1'b1;
            end
            @(negedge clk) tmr_rd = 1'b0;
            check("rdata_upper", 16'h0000, {tmr_rdata[15:8], 8'h00});
            val[8*b +: 8] = tmr_rdata[7:0];
        end
    endtask

    task automatic prog(input logic [1:0] cnt, input logic [2:0] mode, input logic [15:0] val);
        tmr_write(TPORT_CTRL, {cnt, 2'b00, mode, 1'b0});
        tmr_write(cnt, val[7:0]);
        tmr_write(cnt, val[15:8]);
        repeat (2) @(negedge clk);
    endtask

    task automatic set_irq(input logic [1:0] a, input logic [1:0] b);
        irq_value = '{line_b_source_sel: b, line_a_source_sel: a};
        pulse(irq_ctrl_wr);
        pulse(irq_clear);
    endtask

    task automatic convert;
        s0 = n_starts;
        pulse(soft_trig);
        wait_lvl(adc_done, 1'b1, 20);
        wait_lvl(adc_done, 1'b0, 20);
        repeat (4) @(negedge clk);
        check("start_count", 16'(s0 + 1), 16'(n_starts));
    endtask

    initial begin
        void'($urandom(8942));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("status_reset", 16'h0001, 16'(status));
        check("pretrig_reset", 16'h0001, 16'(pretrig_out));
        check("readback_reset", 16'h0000, 16'(readback));
        repeat (4) begin
            mode_value = dtic_mode_s'(4'($urandom) & 4'he);
            pulse(mode_wr);
            set_irq(2'($urandom), 2'($urandom));
            @(negedge clk);
            check("readback", 16'({mode_value, irq_value}), 16'(readback));
        end
        set_irq(SRC_OFF, SRC_OFF);
        convert();
        check("line_a_off", 16'h0000, 16'(line_a));
        pulse(fifo_rd);
        @(negedge clk);
        check("base_data", adc_last, base_data);
        check("status_empty", 16'h0001, 16'(status));
        set_irq(SRC_ONE, SRC_OFF);
        convert();
        check("line_a_eoc", 16'h0001, 16'(line_a));
        convert();
        check("line_a_held", 16'h0001, 16'(line_a));
        pulse(irq_clear);
        repeat (3) @(negedge clk);
        check("line_a_clear", 16'h0000, 16'(line_a));
        convert();
        check("line_a_again", 16'h0001, 16'(line_a));
        set_irq(SRC_TWO, SRC_OFF);
        pulse(fifo_reset);
        @(negedge clk);
        check("fifo_reset", 16'h0001, 16'(status));
        repeat (511) convert();
        check("line_a_below_half", 16'h0000, 16'(line_a));
        convert();
        check("line_a_half", 16'h0001, 16'(line_a));
        check("status_half", 16'h0002, 16'(status));
        repeat (512) pulse(fifo_rd);
        @(negedge clk);
        check("status_block", 16'h0001, 16'(status));
        repeat (1025) convert();
        check("status_full", 16'h0006, 16'(status));
        pulse(fifo_reset);
        @(negedge clk);
        check("fifo_reset_full", 16'h0001, 16'(status));
        set_irq(SRC_OFF, SRC_OFF);
        cval = 16'($urandom_range(16'hff00, 16'h0100));
        for (int m = 0; m < 6; m++) begin
            prog(TPORT_C0, 3'(m), cval + 16'(m));
            read_cnt(v);
            check("count_load", cval + 16'(m), v);
        end
        prog(TPORT_C0, COUNTER_OP_MODE_ZERO, cval);
        check("pretrig_counting", 16'h0000, 16'(pretrig_out));
        convert();
        read_cnt(v);
        check("count_step", cval - 16'h0001, v);
        pulse(counter_stop);
        @(negedge clk);
        check("pretrig_stop", 16'h0001, 16'(pretrig_out));
        read_cnt(v);
        check("count_stop", 16'h0000, v);
        // Divisors keep the rate at or below 110 KHz and their product above 20
        c1 = 16'($urandom_range(20, 10));
        prog(TPORT_C1, COUNTER_OP_MODE_TWO, c1);
        prog(TPORT_C2, COUNTER_OP_MODE_TWO, 16'h000a);
        mode_value = '{pretrig_on: 1'b0, ext_src: 1'b0, autoscan: 1'b0, timer_trig: 1'b1};
        pulse(mode_wr);
        set_irq(SRC_OFF, SRC_ONE);
        wait_lvl(conv_start, 1'b1, 3000);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (conv_start !== 1'b1 && k < 3000);
        check("pacer_period", c1 * 16'h000a, 16'(k));
        check("line_b_pacer", 16'h0001, 16'(line_b));
        set_irq(SRC_OFF, SRC_OFF);
        repeat (450) @(negedge clk);
        check("line_b_off", 16'h0000, 16'(line_b));
        set_irq(SRC_OFF, SRC_TWO);
        prog(TPORT_C1, COUNTER_OP_MODE_TWO, 16'h0000);
        repeat (4) @(negedge clk);
        pulse(irq_clear);
        s0 = n_starts;
        repeat (400) @(negedge clk);
        check("pacer_stopped", 16'(s0), 16'(n_starts));
        check("line_b_no_tick", 16'h0000, 16'(line_b));
        ext_irq = 1'b1;
        wait_lvl(line_b, 1'b1, 8);
        ext_irq = 1'b0;
        check("line_a_quiet", 16'h0000, 16'(line_a));
        print_verdict();
    end
endmodule
